/* hw/spi_mem_map.vh */
`ifndef SPI_MEM_MAP_VH
`define SPI_MEM_MAP_VH
`define CMD_WRITE_LATCH_SET 8'h06
`define CMD_WRITE_LATCH_CLEAR 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_ARRAY_READ 8'h03
`define CMD_ARRAY_WRITE 8'h02
`define CMD_SLEEP_ENTER 8'hb9
`define CMD_SLEEP_EXIT 8'hab
`define MEM_ADDR_BITS 17
`define MEM_DEPTH 131072
`define STAT_WEL_BIT 1
`define STAT_GUARD_BIT 7
`define STAT_RESET 8'h00
`define STAT_WMASK 8'hfd
`define SYS_CLK_MHZ 100
`define SCK_MAX_MHZ 40
`define FIFO_WIDTH 25
`define FIFO_DEPTH 16
`endif

/* hw/sync_2ff.v */
`timescale 1ns/1ns
module sync_2ff #(
	parameter WIDTH = 4
) (
	input wire clk,
	input wire srst,
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_reg;
	always @(posedge clk) begin
		if (srst) begin
			meta_reg <= {WIDTH{1'b0}};
			q <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // sync_2ff

/* hw/word_fifo.v */
`timescale 1ns/1ns
module word_fifo #(
	parameter WIDTH = 25,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire srst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_reg;
	reg [AW:0] rd_reg;
	wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty = wr_reg == rd_reg;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_reg[AW-1:0]];
	always @(posedge clk) begin
		if (in_valid && !full)
			mem[wr_reg[AW-1:0]] <= in_data;
	end
	always @(posedge clk) begin
		if (srst) begin
			wr_reg <= {(AW+1){1'b0}};
			rd_reg <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_reg <= wr_reg + 1'b1;
			if (out_ready && !empty)
				rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule // word_fifo

/* hw/spi_mem_port.v */
`timescale 1ns/1ns
`include "spi_mem_map.vh"
// Behaviour
// - Chip select high: ignore inputs, output released
// - Drive output only while supplying read data
// - Sample rising edges, shift out falling
// - Clock level at select fall picks mode
// - Static logic; master keeps clock <=40 MHz
// - Write guard low blocks status writes when status bit 7 is set
// - Pause low suspends, resumes same point
// - Pause low ignores select and clock
// - First byte command, then address, data
// - One command per select-low period
// - Array is 128K bytes
// - 06h sets write enable latch
// - 04h clears write enable latch
// - 05h shifts status byte out
// - 01h loads status from next byte
// - 02h writes array continuously after address
// - ABh exits sleep
// - Only address bits 0 to 16 used
// - Address increments per byte, wraps to zero
// - Writes need write enable latch set
module spi_mem_port (
	input wire SYS_CLK,
	input wire SRST,
	input wire CS_N,
	input wire SCK,
	input wire MOSI,
	input wire WRITE_GUARD_N,
	input wire PAUSE_N,
	output reg MISO,
	output reg MISO_OE,
	output reg SCK_MODE3,
	output reg SLEEPING
);
	localparam ST_IDLE = 6'b000001;
	localparam ST_CMD = 6'b000010;
	localparam ST_ADDR = 6'b000100;
	localparam ST_RDATA = 6'b001000;
	localparam ST_WDATA = 6'b010000;
	localparam ST_DONE = 6'b100000;

	wire [3:0] pin_sync;
	wire cs_n_s = pin_sync[0];
	wire sck_s = pin_sync[1];
	wire mosi_s = pin_sync[2];
	wire pause_s = pin_sync[3];
	wire guard_s;

	sync_2ff #(.WIDTH(4)) u_sync (
		.clk(SYS_CLK),
		.srst(SRST),
		.d({PAUSE_N, MOSI, SCK, CS_N}),
		.q(pin_sync)
	);
	sync_2ff #(.WIDTH(1)) u_sync_guard (
		.clk(SYS_CLK),
		.srst(SRST),
		.d(WRITE_GUARD_N),
		.q(guard_s)
	);

	reg [7:0] mem [0:`MEM_DEPTH-1];
	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg sck_d_reg;
	reg cs_d_reg;
	reg [2:0] bit_reg;
	reg [1:0] abyte_reg;
	reg [7:0] shift_reg;
	reg [7:0] cmd_reg;
	reg [23:0] addr_reg;
	reg [7:0] status_reg;
	reg [7:0] out_reg;
	reg out_load_reg;
	reg rd_fetch_reg;

	// Frozen view of link while paused
	wire live = pause_s;
	wire sck_rise = live && sck_s && !sck_d_reg && !cs_n_s;
	wire sck_fall = live && !sck_s && sck_d_reg && !cs_n_s;
	wire cs_fall = live && !cs_n_s && cs_d_reg;
	wire cs_rise = live && cs_n_s && !cs_d_reg;
	wire [7:0] byte_in = {shift_reg[6:0], mosi_s};
	wire byte_done = sck_rise && (bit_reg == 3'd7);

	function is_known;
		input [7:0] c;
		begin
			is_known = (c == `CMD_WRITE_LATCH_SET) || (c == `CMD_WRITE_LATCH_CLEAR) ||
				(c == `CMD_STATUS_READ) || (c == `CMD_STATUS_WRITE) ||
				(c == `CMD_ARRAY_READ) || (c == `CMD_ARRAY_WRITE) ||
				(c == `CMD_SLEEP_ENTER) || (c == `CMD_SLEEP_EXIT);
		end
	endfunction

	function is_addr_cmd;
		input [7:0] c;
		begin
			is_addr_cmd = (c == `CMD_ARRAY_READ) || (c == `CMD_ARRAY_WRITE);
		end
	endfunction

	wire write_enable_latch = status_reg[`STAT_WEL_BIT];
	wire status_wr_ok = write_enable_latch && (!status_reg[`STAT_GUARD_BIT] || guard_s);

	// Array writes queue through the FIFO; SCK at 40 MHz gives 20+ system clocks per byte
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`FIFO_WIDTH-1:0] fifo_out_data;
	// Status write bytes must never reach the array
	wire wr_push = (state_reg == ST_WDATA) && (cmd_reg == `CMD_ARRAY_WRITE) && byte_done && write_enable_latch
		&& fifo_in_ready;

	word_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(4)) u_fifo (
		.clk(SYS_CLK),
		.srst(SRST),
		.in_valid(wr_push),
		.in_ready(fifo_in_ready),
		.in_data({addr_reg[`MEM_ADDR_BITS-1:0], byte_in}),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1),
		.out_data(fifo_out_data)
	);

	always @(posedge SYS_CLK) begin
		if (fifo_out_valid)
			mem[fifo_out_data[24:8]] <= fifo_out_data[7:0];
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cs_fall)
					state_next = ST_CMD;
			end
			ST_CMD: begin
				if (byte_done) begin
					if (is_addr_cmd(byte_in))
						state_next = ST_ADDR;
					else if (byte_in == `CMD_STATUS_READ)
						state_next = ST_RDATA;
					else if (byte_in == `CMD_STATUS_WRITE)
						state_next = ST_WDATA;
					else
						state_next = ST_DONE;
				end
			end
			ST_ADDR: begin
				if (byte_done && abyte_reg == 2'd2)
					state_next = (cmd_reg == `CMD_ARRAY_READ) ? ST_RDATA : ST_WDATA;
			end
			ST_RDATA: state_next = ST_RDATA;
			ST_WDATA: begin
				if (byte_done && cmd_reg == `CMD_STATUS_WRITE)
					state_next = ST_DONE;
			end
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
		if (cs_rise || (cs_n_s && live))
			state_next = ST_IDLE;
	end

	always @(posedge SYS_CLK) begin
		if (SRST) begin
			state_reg <= ST_IDLE;
			sck_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
			bit_reg <= 3'd0;
			abyte_reg <= 2'd0;
			shift_reg <= 8'h00;
			cmd_reg <= 8'h00;
			addr_reg <= 24'h000000;
			status_reg <= `STAT_RESET;
			out_reg <= 8'h00;
			out_load_reg <= 1'b0;
			rd_fetch_reg <= 1'b0;
			MISO <= 1'b0;
			MISO_OE <= 1'b0;
			SCK_MODE3 <= 1'b0;
			SLEEPING <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (live) begin
				sck_d_reg <= sck_s;
				cs_d_reg <= cs_n_s;
			end
			if (cs_fall) begin
				SCK_MODE3 <= sck_s;
				bit_reg <= 3'd0;
				abyte_reg <= 2'd0;
			end
			if (sck_rise && state_reg != ST_IDLE) begin
				shift_reg <= byte_in;
				bit_reg <= bit_reg + 3'd1;
			end
			if (byte_done) begin
				case (state_reg)
					ST_CMD: begin
						cmd_reg <= byte_in;
						if (byte_in == `CMD_WRITE_LATCH_SET)
							status_reg[`STAT_WEL_BIT] <= 1'b1;
						if (byte_in == `CMD_WRITE_LATCH_CLEAR)
							status_reg[`STAT_WEL_BIT] <= 1'b0;
						if (byte_in == `CMD_SLEEP_ENTER)
							SLEEPING <= 1'b1;
						if (byte_in == `CMD_SLEEP_EXIT)
							SLEEPING <= 1'b0;
						if (byte_in == `CMD_STATUS_READ) begin
							out_reg <= status_reg;
							out_load_reg <= 1'b1;
						end
						if (!is_known(byte_in))
							out_load_reg <= 1'b0;
					end
					ST_ADDR: begin
						addr_reg <= {addr_reg[15:0], byte_in};
						abyte_reg <= abyte_reg + 2'd1;
						if (abyte_reg == 2'd2 && cmd_reg == `CMD_ARRAY_READ)
							rd_fetch_reg <= 1'b1;
					end
					ST_WDATA: begin
						if (cmd_reg == `CMD_STATUS_WRITE && status_wr_ok)
							status_reg <= (byte_in & `STAT_WMASK) | (status_reg & ~`STAT_WMASK);
						if (cmd_reg == `CMD_ARRAY_WRITE)
							addr_reg <= {7'h00, addr_reg[`MEM_ADDR_BITS-1:0] + 17'd1};
					end
					ST_RDATA: begin
						if (cmd_reg == `CMD_ARRAY_READ)
							rd_fetch_reg <= 1'b1;
					end
					default: begin
					end
				endcase
			end
			if (rd_fetch_reg) begin
				out_reg <= mem[addr_reg[`MEM_ADDR_BITS-1:0]];
				addr_reg <= {7'h00, addr_reg[`MEM_ADDR_BITS-1:0] + 17'd1};
				out_load_reg <= 1'b1;
				rd_fetch_reg <= 1'b0;
			end
			// Falling edge drives next bit; loaded byte goes out MSB first
			if (state_reg == ST_RDATA && sck_fall) begin
				MISO_OE <= 1'b1;
				if (bit_reg == 3'd0 && out_load_reg) begin
					MISO <= out_reg[7];
					out_reg <= {out_reg[6:0], 1'b0};
					out_load_reg <= 1'b0;
				end else begin
					MISO <= out_reg[7];
					out_reg <= {out_reg[6:0], 1'b0};
				end
			end
			if (state_reg != ST_RDATA || !live || cs_n_s)
				MISO_OE <= 1'b0;
		end
	end
endmodule // spi_mem_port

/* verif/spi_master_model.sv */
`timescale 1ns/1ns
module spi_master_model (
	input wire clk,
	input wire miso,
	input wire miso_oe,
	output reg cs_n = 1'b1,
	output reg sck = 1'b0,
	output reg mosi = 1'b0,
	output reg rx_done = 1'b0,
	output reg [7:0] rx_byte = 8'h00
);
	reg mode3 = 1'b0;
	reg seen;
	// Released line keeps moving, so a stale bit never looks valid
	always @(posedge clk) if (cs_n) mosi <= ~mosi;
	task sel(input m);
		mode3 <= m;
		sck <= m;
		repeat (4) @(posedge clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task xfer(input [7:0] tx);
		seen = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'b0;
			mosi <= tx[i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			rx_byte[i] <= miso;
			seen = seen | miso_oe;
		end
		if (seen) begin
			rx_done <= 1'b1;
			@(posedge clk);
			rx_done <= 1'b0;
		end
	endtask
	// Even count: ends selected, clock back at its level
	task jitter;
		repeat (4) begin
			sck <= ~sck;
			cs_n <= ~cs_n;
			repeat (4) @(posedge clk);
		end
	endtask
	task desel;
		sck <= mode3;
		cs_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
endmodule // spi_master_model

/* verif/spi_mem_port_chk.sv */
`timescale 1ns/1ns
module spi_mem_port_chk (
	input wire SYS_CLK,
	input wire SRST,
	input wire CS_N,
	input wire SCK,
	input wire PAUSE_N,
	input wire MISO,
	input wire MISO_OE,
	input wire SCK_MODE3,
	input wire SLEEPING
);
	reg [6:0] low_cnt;
	// A select blip under pause is no new frame
	always @(posedge SYS_CLK)
		if (SRST || (CS_N && PAUSE_N)) low_cnt <= 7'h00;
		else if (low_cnt != 7'h7f) low_cnt <= low_cnt + 7'h01;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	sequence desel_held; CS_N [*5]; endsequence
	sequence pause_held; !PAUSE_N [*5]; endsequence
	chk_desel_quiet: assert property (desel_held |-> !MISO_OE)
		else $error("drive while deselected");
	chk_pause_quiet: assert property (pause_held |-> !MISO_OE)
		else $error("drive while paused");
	chk_oe_cause: assert property ($rose(MISO_OE)
		|-> !$past(CS_N, 2) && $past(PAUSE_N, 2)) else $error("drive without live select");
	chk_oe_after_cmd: assert property ($rose(MISO_OE) |-> low_cnt >= 7'h28)
		else $error("drive before command byte");
	chk_out_on_fall: assert property (MISO_OE && $past(MISO_OE) && $changed(MISO)
		|-> !$past(SCK) && !$past(SCK, 2)) else $error("output moved off a fall");
	chk_mode_capture: assert property ($fell(CS_N) && PAUSE_N
		|-> ##5 SCK_MODE3 == $past(SCK, 5)) else $error("mode not clock level at select");
	chk_mode_cause: assert property ($changed(SCK_MODE3) |-> !$past(CS_N, 2))
		else $error("mode moved without select");
	chk_pause_frozen: assert property (pause_held |-> $stable(SCK_MODE3) && $stable(SLEEPING))
		else $error("state moved while paused");
endmodule // spi_mem_port_chk
bind spi_mem_port spi_mem_port_chk u_chk (.SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N), .SCK(SCK),
	.PAUSE_N(PAUSE_N), .MISO(MISO), .MISO_OE(MISO_OE), .SCK_MODE3(SCK_MODE3), .SLEEPING(SLEEPING));

/* verif/spi_mem_port_tb_top.sv */
`timescale 1ns/1ns
`include "spi_mem_map.vh"
module spi_mem_port_tb_top;
	reg SYS_CLK = 1'b0;
	reg SRST = 1'b1;
	reg WRITE_GUARD_N = 1'b1;
	reg PAUSE_N = 1'b1;
	wire CS_N, SCK, MOSI, MISO, MISO_OE, SCK_MODE3, SLEEPING, rx_done;
	wire [7:0] rx_byte;
	reg [7:0] exp_q[$];
	reg [7:0] tx_q[$];
	reg [7:0] d0, d1;
	reg [16:0] seed = 17'h156ea;
	integer n_fail = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	spi_mem_port DUT (.SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N), .SCK(SCK), .MOSI(MOSI), .PAUSE_N(PAUSE_N),
		.WRITE_GUARD_N(WRITE_GUARD_N), .MISO(MISO), .MISO_OE(MISO_OE), .SCK_MODE3(SCK_MODE3), .SLEEPING(SLEEPING));
	spi_master_model mst (.clk(SYS_CLK), .miso(MISO), .miso_oe(MISO_OE), .cs_n(CS_N), .sck(SCK), .mosi(MOSI),
		.rx_done(rx_done), .rx_byte(rx_byte));
	initial forever #5 SYS_CLK = ~SYS_CLK;
	function [7:0] next8();
		seed = {seed[15:0], seed[16] ^ seed[13]};
		return seed[7:0];
	endfunction
	task cmp_byte(input [7:0] e, input [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD read_byte exp %h got %h", e, g);
		end
	endtask
	task cmp_flag(input string nm, input e, input g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0s exp %b got %b", nm, e, g);
		end
	endtask
	task end_sim;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task frame(input m);
		mst.sel(m);
		while (tx_q.size() > 0) mst.xfer(tx_q.pop_front());
		mst.desel;
	endtask
	task cmd1(input [7:0] c);
		tx_q = '{c};
		frame(1'b0);
	endtask
	task cmd2(input [7:0] c, input [7:0] d);
		tx_q = '{c, d};
		frame(1'b0);
	endtask
	task st_rd(input [7:0] e);
		exp_q.push_back(e);
		cmd2(`CMD_STATUS_READ, next8());
	endtask
	task wr_stat(input [7:0] v);
		cmd1(`CMD_WRITE_LATCH_SET);
		cmd2(`CMD_STATUS_WRITE, v);
		cmd1(`CMD_WRITE_LATCH_CLEAR);
	endtask
	always @(posedge SYS_CLK) if (rx_done) cmp_byte(exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_byte);
	always @(posedge SYS_CLK) if (++cyc == 9000) begin
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (20) @(posedge SYS_CLK);
		SRST <= 1'b0;
		repeat (4) @(posedge SYS_CLK);
		st_rd(8'h00);
		cmd2(`CMD_STATUS_WRITE, 8'hf3);
		st_rd(8'h00);
		tx_q = '{`CMD_WRITE_LATCH_SET, `CMD_WRITE_LATCH_CLEAR};
		frame(1'b0);
		st_rd(8'h02);
		cmd1(`CMD_WRITE_LATCH_CLEAR);
		st_rd(8'h00);
		wr_stat(8'hf3);
		st_rd(8'hf1);
		WRITE_GUARD_N <= 1'b0;
		wr_stat(8'h00);
		st_rd(8'hf1);
		WRITE_GUARD_N <= 1'b1;
		$display("test status done");
		d0 = next8();
		d1 = next8();
		cmd1(`CMD_WRITE_LATCH_SET);
		tx_q = '{`CMD_ARRAY_WRITE, 8'hff, 8'hff, 8'hff, d0, d1};
		frame(1'b1);
		cmd1(`CMD_WRITE_LATCH_CLEAR);
		tx_q = '{`CMD_ARRAY_WRITE, 8'h00, 8'h00, 8'h00, ~d1};
		frame(1'b0);
		exp_q.push_back(d0);
		exp_q.push_back(d1);
		tx_q = '{`CMD_ARRAY_READ, 8'h03, 8'hff, 8'hff, next8()};
		mst.sel(1'b1);
		while (tx_q.size() > 0) mst.xfer(tx_q.pop_front());
		cmp_flag("sck_mode3", 1'b1, SCK_MODE3);
		PAUSE_N <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		mst.jitter;
		PAUSE_N <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
		mst.xfer(next8());
		mst.desel;
		$display("test array done");
		cmd2(8'h5a, next8());
		st_rd(8'hf1);
		cmd1(`CMD_SLEEP_ENTER);
		cmp_flag("sleeping", 1'b1, SLEEPING);
		cmp_flag("sck_mode3", 1'b0, SCK_MODE3);
		cmd1(`CMD_SLEEP_EXIT);
		cmp_flag("sleeping", 1'b0, SLEEPING);
		$display("test misc done");
		cmp_byte(8'h00, 8'(exp_q.size()));
		end_sim;
	end
endmodule // spi_mem_port_tb_top
